// ### rtl/ssp_params.svh
// Purpose: constants for the synchronous serial port pin block
// Assumes: 200 MHz mclk, AXI4-Lite register access
// Notes: byte offsets of the control and status words
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
`define SSP_CTRL_OFS 4'h0
`define SSP_TXDATA_OFS 4'h4
`define SSP_RXDATA_OFS 4'h8
`define SSP_STAT_OFS 4'hC
`define SSP_CTRL_ENABLE 0
`define SSP_CTRL_TXFS_OUT 1
`define SSP_CTRL_TXCLK_OUT 2
`define SSP_CTRL_RXFS_OUT 3
`define SSP_CTRL_RXCLK_OUT 4
`define SSP_CTRL_TX_FALL 5
`define SSP_CTRL_RX_FALL 6
`define SSP_CTRL_RST 32'h0000_0000
`define SSP_CLK_MCLK_HZ 200000000
`define SSP_BCLK_MIN_HZ 512000
`define SSP_BCLK_MAX_HZ 8192000
// half period of the generated bit clock, rounded so that the rate stays <= max
`define SSP_HALF_DIV ((`SSP_CLK_MCLK_HZ + 2 * `SSP_BCLK_MAX_HZ - 1) / (2 * `SSP_BCLK_MAX_HZ))
`define SSP_HALF_DIV_MAX (`SSP_CLK_MCLK_HZ / (2 * `SSP_BCLK_MIN_HZ))
`define SSP_WORD_BITS 8
`endif

// ### rtl/ssp_pkg.sv
// Purpose: types for the synchronous serial port pin block
// Assumes: constants live in ssp_params.svh
// Notes: pin bundles travel as packed structs
package ssp_pkg;
    typedef struct packed {
        logic txFrameSync;
        logic txBitClock;
        logic rxFrameSync;
        logic rxBitClock;
        logic rxSerialData;
    } ssp_pin_in_t;
    typedef struct packed {
        logic txFrameSync;
        logic txFrameSyncOe;
        logic txBitClock;
        logic txBitClockOe;
        logic rxFrameSync;
        logic rxFrameSyncOe;
        logic rxBitClock;
        logic rxBitClockOe;
        logic txSerialData;
        logic txSerialDataOe;
    } ssp_pin_out_t;
endpackage : ssp_pkg

// ### rtl/ssp_serial_port.sv
// Purpose: pin logic of one synchronous serial port, with AXI4-Lite control
// Assumes: link pins are asynchronous to mclk and are double-registered
// Notes: 8-bit frames, one frame sync pulse during the first bit
// How it works
// - transmit frame sync direction selectable, input after reset
// - transmit bit clock direction selectable, input after reset
// - generated bit clock stays within 512K-8.192M
// - transmit data/sync launched on selected edge
// - receive data sampled on selected edge
// - receive bit clock selectable, input, in range
// - receive frame sync direction selectable, input after reset
// - transmit data open drain: low or released
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`include "ssp_params.svh"
`default_nettype none
module ssp_serial_port #(
    parameter int HALF_DIV = `SSP_HALF_DIV
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // axi4-lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial pins
    input wire ssp_pkg::ssp_pin_in_t pinIn,
    output ssp_pkg::ssp_pin_out_t pinOut
);
    import ssp_pkg::*;

    localparam int WB = `SSP_WORD_BITS;
    localparam logic [15:0] HALF_CNT = 16'(HALF_DIV - 1);

    logic [31:0] ctrl_r;
    logic [WB-1:0] txWord_r;
    logic [WB-1:0] rxWord_r;
    logic rxDone_r;
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic [4:0] prev_r;
    logic [15:0] divCnt_r;
    logic genClk_r;
    logic [WB-1:0] txShift_r;
    logic [2:0] txBit_r;
    logic txFsOut_r;
    logic txDataLow_r;
    logic [WB-1:0] rxShift_r;
    logic [2:0] rxBit_r;
    logic rxFsOut_r;
    logic [2:0] rxGenBit_r;
    logic awHeld_r;
    logic wHeld_r;
    logic [3:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    ssp_pin_out_t pinOut_r;

    logic enable;
    logic txClk;
    logic rxClk;
    logic txFs;
    logic rxFs;
    logic txEdge;
    logic rxEdge;

    function automatic logic edgeSel(input logic now, input logic was, input logic fall);
        edgeSel = fall ? (was & ~now) : (now & ~was);
    endfunction : edgeSel

    assign enable = ctrl_r[`SSP_CTRL_ENABLE];

    // two-flop synchronisers for all incoming pins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            prev_r <= 5'h00;
        end else begin
            sync1_r <= pinIn;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // bit clock generator for output-direction clocks
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt_r <= 16'h0000;
            genClk_r <= 1'b0;
        end else if (!enable) begin
            divCnt_r <= 16'h0000;
            genClk_r <= 1'b0;
        end else if (divCnt_r == HALF_CNT) begin
            divCnt_r <= 16'h0000;
            genClk_r <= ~genClk_r;
        end else begin
            divCnt_r <= divCnt_r + 16'h0001;
        end
    end

    logic txClkPrev_r;
    logic rxClkPrev_r;
    logic rxFsPrev_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            txClkPrev_r <= 1'b0;
            rxClkPrev_r <= 1'b0;
            rxFsPrev_r <= 1'b0;
        end else begin
            txClkPrev_r <= txClk;
            rxClkPrev_r <= rxClk;
            rxFsPrev_r <= rxFs;
        end
    end

    // pick the pin or the internal source per direction
    assign txClk = ctrl_r[`SSP_CTRL_TXCLK_OUT] ? genClk_r : sync2_r[3];
    assign rxClk = ctrl_r[`SSP_CTRL_RXCLK_OUT] ? genClk_r : sync2_r[1];
    assign txFs = ctrl_r[`SSP_CTRL_TXFS_OUT] ? 1'b0 : sync2_r[4];
    assign rxFs = ctrl_r[`SSP_CTRL_RXFS_OUT] ? rxFsOut_r : sync2_r[2];
    assign txEdge = edgeSel(txClk, txClkPrev_r, ctrl_r[`SSP_CTRL_TX_FALL]);
    assign rxEdge = edgeSel(rxClk, rxClkPrev_r, ctrl_r[`SSP_CTRL_RX_FALL]);

    // transmit shifter: frame starts on external sync or on its own when driving sync
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            txShift_r <= '0;
            txBit_r <= 3'h0;
            txFsOut_r <= 1'b0;
            txDataLow_r <= 1'b0;
        end else if (!enable) begin
            txBit_r <= 3'h0;
            txFsOut_r <= 1'b0;
            txDataLow_r <= 1'b0;
        end else if (txEdge) begin
            if (txBit_r == 3'h0 && (ctrl_r[`SSP_CTRL_TXFS_OUT] || txFs)) begin
                txShift_r <= {txWord_r[WB-2:0], 1'b0};
                txDataLow_r <= ~txWord_r[WB-1];
                txFsOut_r <= ctrl_r[`SSP_CTRL_TXFS_OUT];
                txBit_r <= 3'h1;
            end else if (txBit_r != 3'h0) begin
                txShift_r <= {txShift_r[WB-2:0], 1'b0};
                txDataLow_r <= ~txShift_r[WB-1];
                txFsOut_r <= 1'b0;
                txBit_r <= txBit_r + 3'h1;
            end else begin
                txDataLow_r <= 1'b0;
                txFsOut_r <= 1'b0;
            end
        end
    end

    // receive frame sync generator when driving the pin
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rxFsOut_r <= 1'b0;
            rxGenBit_r <= 3'h0;
        end else if (!enable || !ctrl_r[`SSP_CTRL_RXFS_OUT]) begin
            rxFsOut_r <= 1'b0;
            rxGenBit_r <= 3'h0;
        end else if (rxClk & ~rxClkPrev_r) begin
            rxFsOut_r <= (rxGenBit_r == 3'h0);
            rxGenBit_r <= rxGenBit_r + 3'h1;
        end
    end

    // receive shifter
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rxShift_r <= '0;
            rxBit_r <= 3'h0;
            rxWord_r <= '0;
            rxDone_r <= 1'b0;
        end else begin
            if (!enable) begin
                rxBit_r <= 3'h0;
            end else if (rxEdge) begin
                if (rxBit_r != 3'h0 || rxFs) begin
                    rxShift_r <= {rxShift_r[WB-2:0], sync2_r[0]};
                    rxBit_r <= rxBit_r + 3'h1;
                    if (rxBit_r == 3'h7) begin
                        rxWord_r <= {rxShift_r[WB-2:0], sync2_r[0]};
                    end
                end
            end
            // set wins over the clear on a data read
            if (enable && rxEdge && rxBit_r == 3'h7) begin
                rxDone_r <= 1'b1;
            end else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == `SSP_RXDATA_OFS) begin
                rxDone_r <= 1'b0;
            end
        end
    end

    // pin drivers: inputs until enabled and set to output
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pinOut_r <= '0;
        end else begin
            pinOut_r.txFrameSync <= txFsOut_r;
            pinOut_r.txFrameSyncOe <= enable & ctrl_r[`SSP_CTRL_TXFS_OUT];
            pinOut_r.txBitClock <= genClk_r;
            pinOut_r.txBitClockOe <= enable & ctrl_r[`SSP_CTRL_TXCLK_OUT];
            pinOut_r.rxFrameSync <= rxFsOut_r;
            pinOut_r.rxFrameSyncOe <= enable & ctrl_r[`SSP_CTRL_RXFS_OUT];
            pinOut_r.rxBitClock <= genClk_r;
            pinOut_r.rxBitClockOe <= enable & ctrl_r[`SSP_CTRL_RXCLK_OUT];
            pinOut_r.txSerialData <= 1'b0;
            pinOut_r.txSerialDataOe <= enable & txDataLow_r;
        end
    end
    assign pinOut = pinOut_r;

    // axi4-lite write: address and data in either order
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 4'h0;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            ctrl_r <= `SSP_CTRL_RST;
            txWord_r <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (awHeld_r && wHeld_r && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                if (awAddr_r == `SSP_CTRL_OFS && wStrb_r[0]) begin
                    ctrl_r <= {25'h0, wData_r[6:0]};
                end else if (awAddr_r == `SSP_TXDATA_OFS && wStrb_r[0]) begin
                    txWord_r <= wData_r[WB-1:0];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                // both channels reopen once the response is taken
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    assign s_axi_bresp = 2'h0;

    // axi4-lite read
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
            s_axi_arready <= 1'b1;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rresp <= 2'h0;
            if (s_axi_araddr == `SSP_CTRL_OFS) begin
                s_axi_rdata <= ctrl_r;
            end else if (s_axi_araddr == `SSP_TXDATA_OFS) begin
                s_axi_rdata <= {24'h0, txWord_r};
            end else if (s_axi_araddr == `SSP_RXDATA_OFS) begin
                s_axi_rdata <= {24'h0, rxWord_r};
            end else if (s_axi_araddr == `SSP_STAT_OFS) begin
                s_axi_rdata <= {27'h0, sync2_r[0], txBit_r != 3'h0, rxBit_r != 3'h0,
                    rxDone_r, enable};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'h2;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule : ssp_serial_port
`default_nettype wire

// ### verif/ssp_serial_port_props.sv
// Purpose: pin checker for ssp_serial_port
// Assumes: aw and w taken at one edge
// Notes: bound below
`timescale 1ns/100ps
`default_nettype none
module ssp_serial_port_props
    import ssp_pkg::*;
#(
    parameter int HALF_DIV = 13
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // write request
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    // pins
    input wire ssp_pkg::ssp_pin_out_t pinOut
);
    logic [6:0] ctrl_r, old_r, old2_r;
    logic [15:0] run_r;
    logic arm_r;
    logic [3:0] oe, ok;
    assign oe = {pinOut.rxBitClockOe, pinOut.rxFrameSyncOe, pinOut.txBitClockOe,
        pinOut.txFrameSyncOe};
    assign ok = {4{ctrl_r[0]}} & ctrl_r[4:1] | {4{old_r[0]}} & old_r[4:1]
        | {4{old2_r[0]}} & old2_r[4:1];
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    // control shadow and bit clock level length
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= 7'h00;
            old_r <= 7'h00;
            old2_r <= 7'h00;
            run_r <= 16'h0000;
            arm_r <= 1'h0;
        end else begin
            old_r <= ctrl_r;
            old2_r <= old_r;
            if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                && s_axi_awaddr == 4'h0) begin
                ctrl_r <= s_axi_wdata[6:0];
            end
            run_r <= $changed(pinOut.txBitClock) ? 16'h0001 : run_r + 16'h0001;
            arm_r <= pinOut.txBitClockOe && (arm_r || $changed(pinOut.txBitClock));
        end
    end
    dir_match_a: assert property ($stable(ctrl_r) [*3]
        |-> oe == ({4{ctrl_r[0]}} & ctrl_r[4:1])) else $error("bad direction");
    oe_gate_a: assert property ((oe & ~ok) == 4'h0)
        else $error("pin driven while off");
    od_low_a: assert property (pinOut.txSerialData == 1'h0)
        else $error("tx data driven high");
    od_gate_a: assert property (
        pinOut.txSerialDataOe |-> ctrl_r[0] || old_r[0] || old2_r[0])
        else $error("tx data driven while off");
    off_quiet_a: assert property (
        !ctrl_r[0] && !old_r[0] && !old2_r[0] |=> pinOut == '0)
        else $error("pins not released");
    clk_rate_a: assert property (
        arm_r && pinOut.txBitClockOe && $changed(pinOut.txBitClock) |-> run_r == HALF_DIV)
        else $error("bad half period");
    clk_pair_a: assert property (
        pinOut.rxBitClockOe && pinOut.txBitClockOe |-> pinOut.rxBitClock == pinOut.txBitClock)
        else $error("rx clock differs");
    launch_a: assert property (
        ctrl_r[0] && ctrl_r[2] && $changed(pinOut.txSerialDataOe) |-> pinOut.txBitClock
        != ctrl_r[5] && ($changed(pinOut.txBitClock) || run_r < 16'h0007))
        else $error("tx data on wrong edge");
endmodule : ssp_serial_port_props
bind ssp_serial_port ssp_serial_port_props #(.HALF_DIV(HALF_DIV)) props (.mclk(mclk),
    .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .pinOut(pinOut));
`default_nettype wire

// ### verif/ssp_far_end.sv
// Purpose: far-end framer for the serial pins
// Assumes: 8-bit frames, sync high in the first bit
// Notes: its clock stands still between frames
`timescale 1ns/100ps
`default_nettype none
module ssp_far_end
    import ssp_pkg::*;
(
    // pins of the port
    input wire ssp_pkg::ssp_pin_out_t pinOut,
    output var ssp_pkg::ssp_pin_in_t pinIn
);
    logic clk = 1'h0;
    logic sync = 1'h0;
    logic rxd = 1'h1;
    // a pin follows the port while its enable is high
    assign pinIn = {pinOut.txFrameSyncOe ? pinOut.txFrameSync : sync,
        pinOut.txBitClockOe ? pinOut.txBitClock : clk,
        pinOut.rxFrameSyncOe ? pinOut.rxFrameSync : sync,
        pinOut.rxBitClockOe ? pinOut.rxBitClock : clk, rxd};
    // one frame at 8 MHz, msb first
    task automatic frame(input logic fall, input logic [7:0] send, output logic [7:0] got);
        clk = fall;
        for (int i = 7; i >= 0; i--) begin
            rxd = send[i];
            sync = (i == 7);
            #62.5;
            clk = !fall;
            #62.5;
            got[i] = !pinOut.txSerialDataOe; // pull-up reads high
            clk = fall;
        end
        sync = 1'h0;
        rxd = 1'h1;
    endtask : frame
endmodule : ssp_far_end
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: bench for ssp_serial_port
// Assumes: far end in ssp_far_end
// Notes: frames on both edges, then own clocks
`timescale 1ns/100ps
`include "ssp_params.svh"
`default_nettype none
module tb_top;
    import ssp_pkg::*;
    localparam int Half = 13;
    logic mclk = 1'h0;
    logic rst_b = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] got;
    ssp_pin_in_t pinIn;
    ssp_pin_out_t pinOut;
    int numErrors = 0, nChecks = 0, cyc = 0, cnt;
    always #2.5 mclk = !mclk;
    ssp_serial_port #(.HALF_DIV(Half)) dut (.mclk(mclk), .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pinIn(pinIn),
        .pinOut(pinOut));
    ssp_far_end far (.pinOut(pinOut), .pinIn(pinIn));
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            numErrors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        nChecks++;
        if (g !== e) begin
            numErrors++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
    endtask : rd
    // external clock and sync, both edge choices
    task automatic frame_test(input logic f, input logic [7:0] tx, input logic [7:0] rx);
        wr(`SSP_CTRL_OFS, {25'h0, f, f, 5'h01});
        wr(`SSP_TXDATA_OFS, {24'h0, tx});
        far.frame(f, rx, got);
        repeat (8) @(posedge mclk);
        chk(got, tx);
        rd(`SSP_STAT_OFS, d);
        chk(d[1], 1'h1);
        rd(`SSP_RXDATA_OFS, d);
        chk(d[7:0], rx);
        $display("frame test on edge %0d done", f);
    endtask : frame_test
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (6) @(posedge mclk);
        rst_b <= 1'h1;
        @(posedge mclk);
        chk(pinOut, 10'h000);
        rd(`SSP_CTRL_OFS, d);
        chk(d, `SSP_CTRL_RST);
        wr(`SSP_CTRL_OFS, 32'h1);
        repeat (4) @(posedge mclk);
        chk(pinOut, 10'h000);
        $display("reset test done");
        frame_test(1'h0, 8'hA5, 8'h3C);
        frame_test(1'h1, 8'h5A, 8'hC3);
        wr(`SSP_CTRL_OFS, 32'h1F);
        wr(`SSP_TXDATA_OFS, 32'h96);
        repeat (6) @(posedge mclk);
        chk(pinOut & 10'h154, 10'h154);
        while (pinOut.txBitClock !== 1'h0) @(posedge mclk);
        while (pinOut.txBitClock !== 1'h1) @(posedge mclk);
        cnt = 0;
        while (pinOut.txBitClock === 1'h1) begin
            @(posedge mclk);
            cnt++;
        end
        chk(cnt, Half);
        repeat (600) @(posedge mclk);
        wr(`SSP_CTRL_OFS, 32'h0);
        repeat (4) @(posedge mclk);
        chk(pinOut, 10'h000);
        $display("own clock test done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
